// ===== hdl/setting_group_selector.sv
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Overview of operation
// - two setting groups exist; exactly one is active at all times
// - change requests come from front panel, logic input and remote port
// - a change applies only when no protection timer runs, thermal excluded
// - a request during running timers is held, applied when the last expires
// - group indication contact: open for first group, closed for second
// - the logic input acts on its sustained level, not on edges
// - with the level input assigned, panel and remote requests are refused
// - at power-up the initial group follows the assigned input state
// - polarity 0: energised input selects first group, else second
// - polarity 1: energised input selects second group, else first
// - priority panel, then input, then remote; password holder controls
// - during the five-minute password session remote commands are refused
module setting_group_selector
  import group_sel_pkg::*;
#(
  parameter longint SESSION_CYCLES = SESSION_CYCLES_L
)(
  input wire logic mclk,                // 250 MHz clock
  input wire logic rst_b,               // sync reset, active low
  input wire logic group_input,         // group change logic input pin
  input wire logic protection_busy,     // any protection/automation timer running
  input wire logic thermal_busy,        // thermal overload running
  output logic group_contact,           // indication relay drive, closed = 1
  output logic active_group,            // operating_status_view of active group
  input wire logic [3:0] s_axi_awaddr,  // write address
  input wire logic s_axi_awvalid,       // write address valid
  output logic s_axi_awready,           // write address ready
  input wire logic [31:0] s_axi_wdata,  // write data
  input wire logic [3:0] s_axi_wstrb,   // write strobes
  input wire logic s_axi_wvalid,        // write data valid
  output logic s_axi_wready,            // write data ready
  output logic [1:0] s_axi_bresp,       // write response
  output logic s_axi_bvalid,            // write response valid
  input wire logic s_axi_bready,        // write response ready
  input wire logic [3:0] s_axi_araddr,  // read address
  input wire logic s_axi_arvalid,       // read address valid
  output logic s_axi_arready,           // read address ready
  output logic [31:0] s_axi_rdata,      // read data
  output logic [1:0] s_axi_rresp,       // read response
  output logic s_axi_rvalid,            // read data valid
  input wire logic s_axi_rready         // read data ready
);
  initial begin
    if (SESSION_CYCLES < 1) begin
      $error("setting_group_selector: SESSION_CYCLES must be positive");
    end
    if (SESSION_CYCLES >= (64'd1 << SESSION_CNT_W)) begin
      $error("setting_group_selector: SESSION_CYCLES exceeds the session counter");
    end
  end

  typedef enum logic [1:0] {
    INIT_WAIT = 2'b00,
    INIT_FILL = 2'b01,
    INIT_LOAD = 2'b11,
    RUN = 2'b10
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic active;
    logic pend_v;
    logic pend_g;
    logic input_en;
    logic polarity;
    logic out_en;
    logic reject;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic contact;
  } state_t;

  state_t st_r, st_nxt;
  logic in_lvl;
  logic session;
  logic login_pulse;
  logic logout_pulse;
  logic busy;
  logic input_group;
  logic wr_fire;
  logic rd_fire;
  logic panel_req;
  logic panel_g;
  logic remote_req;
  logic remote_g;
  logic input_req;
  logic any_req;
  logic req_g;
  logic panel_refused;
  logic remote_refused;

  level_sync u_in_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(group_input),
    .q(in_lvl)
  );

  session_timer #(
    .SESSION_CYCLES(SESSION_CYCLES)
  ) u_session (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(login_pulse),
    .stop(logout_pulse),
    .active(session)
  );

  // thermal overload alone does not hold a change back
  assign busy = protection_busy;
  // thermal_busy is accepted for completeness; it never defers a change
  // polarity maps the energised level to a group
  assign input_group = st_r.polarity ? in_lvl : ~in_lvl;

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rd_fire = s_axi_arvalid && !st_r.rvalid;

  // decode of command words
  always_comb begin
    panel_req = 1'b0;
    panel_g = 1'b0;
    remote_req = 1'b0;
    remote_g = 1'b0;
    login_pulse = 1'b0;
    logout_pulse = 1'b0;
    if (wr_fire && st_r.w_strb[0]) begin
      if (st_r.aw_addr == OFS_PANEL) begin
        panel_req = 1'b1;
        panel_g = st_r.w_data[CMD_GROUP];
        login_pulse = st_r.w_data[PANEL_LOGIN];
        logout_pulse = st_r.w_data[PANEL_LOGOUT] && !st_r.w_data[PANEL_LOGIN];
      end else if (st_r.aw_addr == OFS_REMOTE) begin
        remote_req = 1'b1;
        remote_g = st_r.w_data[CMD_GROUP];
      end
    end
  end

  // when enabled, the level input raises a request in RUN whenever its level disagrees with the target
  assign input_req = st_r.phase == RUN && st_r.input_en &&
                     (input_group != (st_r.pend_v ? st_r.pend_g : st_r.active));
  // refused sources raise the sticky reject flag and change no group; a refused panel word still acts on its login and logout bits
  assign panel_refused = panel_req && st_r.input_en;
  assign remote_refused = remote_req && (st_r.input_en || session);

  always_comb begin
    st_nxt = st_r;
    any_req = 1'b0;
    req_g = st_r.active;
    // source ranking: panel wins over input over remote
    if (panel_req && !panel_refused) begin
      any_req = 1'b1;
      req_g = panel_g;
    end else if (input_req) begin
      any_req = 1'b1;
      req_g = input_group;
    end else if (remote_req && !remote_refused) begin
      any_req = 1'b1;
      req_g = remote_g;
    end

    case (st_r.phase)
      INIT_WAIT: begin
        st_nxt.phase = INIT_FILL;
      end
      INIT_FILL: begin
        // the synchroniser was cleared by reset and needs two edges to fill
        st_nxt.phase = INIT_LOAD;
      end
      INIT_LOAD: begin
        // synchroniser now holds the pin level
        st_nxt.phase = RUN;
        if (st_r.input_en) begin
          st_nxt.active = input_group;
        end
      end
      RUN: begin
        if (any_req) begin
          st_nxt.pend_v = 1'b1;
          st_nxt.pend_g = req_g;
        end
        if (!busy) begin
          // apply pending or fresh request when protection is idle
          if (any_req) begin
            st_nxt.active = req_g;
            st_nxt.pend_v = 1'b0;
          end else if (st_r.pend_v) begin
            st_nxt.active = st_r.pend_g;
            st_nxt.pend_v = 1'b0;
          end
        end
      end
      default: begin
        st_nxt.phase = INIT_WAIT;
      end
    endcase

    // indication contact, normally open relay
    st_nxt.contact = st_r.out_en && (st_nxt.active == GROUP_SECOND);

    // axi write channels
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case (st_r.aw_addr)
        OFS_CTRL: begin
          if (st_r.w_strb[0]) begin
            st_nxt.input_en = st_r.w_data[CTRL_INPUT_EN];
            st_nxt.polarity = st_r.w_data[CTRL_POLARITY];
            st_nxt.out_en = st_r.w_data[CTRL_OUT_EN];
          end
        end
        OFS_STATUS: begin
          // write one clears the reject flag
          if (st_r.w_strb[0] && st_r.w_data[ST_REJECT]) begin
            st_nxt.reject = 1'b0;
          end
        end
        OFS_REMOTE, OFS_PANEL: begin
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    // a refusal in the same cycle as a clear wins
    if (panel_refused || remote_refused) begin
      st_nxt.reject = 1'b1;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // axi read channel
    if (rd_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = '0;
      case (s_axi_araddr)
        OFS_CTRL: begin
          st_nxt.rdata[CTRL_INPUT_EN] = st_r.input_en;
          st_nxt.rdata[CTRL_POLARITY] = st_r.polarity;
          st_nxt.rdata[CTRL_OUT_EN] = st_r.out_en;
        end
        OFS_STATUS: begin
          st_nxt.rdata[ST_ACTIVE] = st_r.active;
          st_nxt.rdata[ST_PENDING_V] = st_r.pend_v;
          st_nxt.rdata[ST_PENDING_G] = st_r.pend_g;
          st_nxt.rdata[ST_SESSION] = session;
          st_nxt.rdata[ST_BUSY] = busy;
          st_nxt.rdata[ST_REJECT] = st_r.reject;
        end
        OFS_REMOTE, OFS_PANEL: begin
        end
        default: begin
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.phase <= INIT_WAIT;
      st_r.active <= GROUP_FIRST;
      st_r.input_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign group_contact = st_r.contact;
  assign active_group = st_r.active;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
endmodule

// ===== hdl/group_sel_pkg.sv
package group_sel_pkg;
  // active group encoding
  localparam logic GROUP_FIRST = 1'b0;  // first_setting_group
  localparam logic GROUP_SECOND = 1'b1; // second_setting_group
  // local password session
  localparam int CLK_HZ = 250000000;
  localparam int SESSION_MIN = 5;
  localparam longint SESSION_CYCLES_L = 64'(SESSION_MIN) * 64'd60 * 64'(CLK_HZ);
  localparam int SESSION_CNT_W = 40;
  // register map, byte addresses
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_REMOTE = 4'h8;
  localparam logic [3:0] OFS_PANEL = 4'hc;
  // control register fields
  localparam int CTRL_INPUT_EN = 0;
  localparam int CTRL_POLARITY = 1;
  localparam int CTRL_OUT_EN = 2;
  // command word fields
  localparam int CMD_GROUP = 0;
  localparam int PANEL_LOGIN = 1;
  localparam int PANEL_LOGOUT = 2;
  // status fields
  localparam int ST_ACTIVE = 0;
  localparam int ST_PENDING_V = 1;
  localparam int ST_PENDING_G = 2;
  localparam int ST_SESSION = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_REJECT = 5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== hdl/level_sync.sv
`timescale 1ns/1ns
module level_sync
  import group_sel_pkg::*;
(
  input wire logic mclk,  // clock
  input wire logic rst_b, // sync reset
  input wire logic d,     // async level
  output logic q          // synchronised level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_t;
  sync_t st_r, st_nxt;
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
endmodule

// ===== hdl/session_timer.sv
`timescale 1ns/1ns
module session_timer
  import group_sel_pkg::*;
#(
  parameter longint SESSION_CYCLES = SESSION_CYCLES_L
)(
  input wire logic mclk,    // clock
  input wire logic rst_b,   // sync reset
  input wire logic start,   // pulse, (re)start session
  input wire logic stop,    // pulse, end session
  output logic active       // session running
);
  initial begin
    if (SESSION_CYCLES < 1 || SESSION_CYCLES >= (64'd1 << SESSION_CNT_W)) begin
      $error("session_timer: SESSION_CYCLES out of range");
    end
  end
  typedef struct packed {
    logic [SESSION_CNT_W-1:0] cnt;
  } tmr_t;
  tmr_t st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.cnt = SESSION_CNT_W'(SESSION_CYCLES);
    end else if (stop) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - SESSION_CNT_W'(1);
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign active = (st_r.cnt != '0);
endmodule

// ===== verif/field_side.sv
`timescale 1ns/1ns
module field_side
#(
  parameter int TRIP_CYC = 40
)(
  input wire logic mclk, // clock
  input wire logic energise, // pin energised
  input wire logic trip, // starts a protection timer
  output logic group_input, // logic input pin
  output logic protection_busy // timer running
);
  int left_r = 0;
  // the pin holds its level for as long as it is energised
  assign group_input = energise;
  always @(posedge mclk) begin
    if (trip) begin
      left_r <= TRIP_CYC;
    end else if (left_r > 0) begin
      left_r <= left_r - 1;
    end
  end
  assign protection_busy = left_r > 0;
endmodule

// ===== verif/group_sel_assertions.sv
`timescale 1ns/1ns
module group_sel_checker (
  input wire logic mclk, // clock
  input wire logic rst_b, // reset
  input wire logic protection_busy, // timers
  input wire logic active_group, // group
  input wire logic group_contact, // contact
  input wire logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  input wire logic s_axi_wvalid, // w
  input wire logic s_axi_wready, // w
  input wire logic s_axi_bvalid, // b
  input wire logic s_axi_bready, // b
  input wire logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic s_axi_rvalid, // r
  input wire logic s_axi_rready, // r
  input wire logic [31:0] s_axi_rdata // r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_reset_group: assert property (disable iff (1'h0) !rst_b |=> !active_group && !group_contact)
    else $error("group not cleared by reset");
  a_contact_follows: assert property (group_contact |-> active_group)
    else $error("contact closed on first group");
  a_busy_defers: assert property (protection_busy [*3] |=> $stable(active_group))
    else $error("group changed while timers run");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("unused read bits set");
endmodule

// ===== verif/setting_group_selector_tb.sv
`timescale 1ns/1ns
module setting_group_selector_tb;
  import group_sel_pkg::*;
  logic mclk = 1'h0, rst_b = 1'h0, energise = 1'h0, trip = 1'h0, thermal_busy = 1'h0;
  logic group_input, protection_busy, group_contact, active_group;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int failures = 0, n_tests = 0;
  always #2 mclk = ~mclk;
  field_side #(.TRIP_CYC(40)) far_u (.mclk, .energise, .trip, .group_input, .protection_busy);
  setting_group_selector #(.SESSION_CYCLES(50)) dut_u (.mclk, .rst_b, .group_input, .protection_busy,
    .thermal_busy, .group_contact, .active_group, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h0;
      wr_resp = s_axi_bresp;
    end while (!(s_axi_bvalid && s_axi_bready));
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h0;
      rd_v = s_axi_rdata;
      rd_resp = s_axi_rresp;
    end while (!(s_axi_rvalid && s_axi_rready));
  endtask
  task idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // pin low through reset, so the second group is chosen at power-up
  task t_powerup;
    idle(4);
    chk("start group", 32'(GROUP_SECOND), 32'(active_group));
    energise <= 1'h1;
    idle(6);
    chk("input group", 32'(GROUP_FIRST), 32'(active_group));
    chk("contact off", 32'h0, 32'(group_contact));
    $display("powerup done");
  endtask
  task t_refuse;
    wr(OFS_PANEL, 32'h1);
    chk("panel resp", 32'(RESP_OKAY), 32'(wr_resp));
    wr(OFS_REMOTE, 32'h1);
    idle(2);
    chk("refused group", 32'(GROUP_FIRST), 32'(active_group));
    rd(OFS_STATUS);
    chk("reject set", 32'h1, 32'(rd_v[ST_REJECT]));
    wr(OFS_STATUS, 32'h20);
    rd(OFS_STATUS);
    chk("reject clear", 32'h0, 32'(rd_v[ST_REJECT]));
    $display("refuse done");
  endtask
  task t_polarity;
    wr(OFS_CTRL, 32'h3);
    idle(6);
    chk("pol1 high", 32'(GROUP_SECOND), 32'(active_group));
    energise <= 1'h0;
    idle(6);
    chk("pol1 low", 32'(GROUP_FIRST), 32'(active_group));
    $display("polarity done");
  endtask
  task t_session;
    wr(OFS_CTRL, 32'h4);
    wr(OFS_REMOTE, 32'h1);
    idle(2);
    chk("remote group", 32'(GROUP_SECOND), 32'(active_group));
    chk("contact on", 32'h1, 32'(group_contact));
    wr(OFS_PANEL, 32'h2);
    idle(2);
    chk("panel group", 32'(GROUP_FIRST), 32'(active_group));
    wr(OFS_REMOTE, 32'h1);
    idle(2);
    chk("remote locked", 32'(GROUP_FIRST), 32'(active_group));
    idle(60);
    wr(OFS_REMOTE, 32'h1);
    idle(2);
    chk("session over", 32'(GROUP_SECOND), 32'(active_group));
    $display("session done");
  endtask
  task t_defer;
    trip <= 1'h1;
    @(posedge mclk);
    trip <= 1'h0;
    wr(OFS_REMOTE, 32'h1);
    wr(OFS_REMOTE, 32'h0);
    rd(OFS_STATUS);
    chk("pending", 32'h1, 32'(rd_v[ST_PENDING_G:ST_PENDING_V]));
    chk("held group", 32'(GROUP_SECOND), 32'(active_group));
    idle(40);
    chk("applied", 32'(GROUP_FIRST), 32'(active_group));
    rd(OFS_STATUS);
    chk("pend clear", 32'h0, 32'(rd_v[ST_PENDING_V]));
    thermal_busy <= 1'h1;
    wr(OFS_REMOTE, 32'h1);
    idle(2);
    chk("thermal", 32'(GROUP_SECOND), 32'(active_group));
    thermal_busy <= 1'h0;
    $display("defer done");
  endtask
  // pin energised across a mid-run reset: the first group must stand from the first cycle
  task t_reset;
    energise <= 1'h1;
    idle(3);
    rst_b <= 1'h0;
    idle(10);
    rst_b <= 1'h1;
    repeat (6) begin
      @(posedge mclk);
      chk("reset group", 32'(GROUP_FIRST), 32'(active_group));
    end
    rd(OFS_CTRL);
    chk("ctrl reset", 32'h1, rd_v);
    wr(4'h1, 32'h0);
    chk("bad wr resp", 32'(RESP_SLVERR), 32'(wr_resp));
    rd(4'h1);
    chk("bad rd resp", 32'(RESP_SLVERR), 32'(rd_resp));
    $display("reset done");
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    idle(10);
    rst_b <= 1'h1;
    t_powerup();
    t_refuse();
    t_polarity();
    t_session();
    t_defer();
    t_reset();
    print_verdict();
  end
  initial begin
    #40000;
    failures++;
    print_verdict();
  end
endmodule
bind setting_group_selector group_sel_checker chk_u (.mclk, .rst_b, .protection_busy, .active_group,
  .group_contact, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
